// [cbx_pkg.sv]
package cbx_pkg;
    // ==========================================================
    // Register map (byte addresses)
    localparam logic [11:0] CBX_INSTR_OFS  = 12'h000;
    localparam logic [11:0] CBX_STATUS_OFS = 12'h004;
    localparam logic [11:0] CBX_STATUS_REGISTER_OFS   = 12'h008;
    localparam logic [11:0] CBX_PC_OFS     = 12'h00c;
    localparam logic [11:0] CBX_GPR_BASE   = 12'h100;
    localparam logic [11:0] CBX_IO_BASE    = 12'h200;
    localparam logic [11:0] CBX_DMEM_BASE  = 12'h400;
    localparam int          CBX_GPR_N      = 32;
    localparam int          CBX_IO_N       = 32;
    localparam int          CBX_DMEM_N     = 256;
    localparam logic [7:0]  CBX_STATUS_REGISTER_RST   = 8'h00;
    localparam logic [15:0] CBX_PC_RST     = 16'h0000;
    // ==========================================================
    // Status register bit positions
    localparam int CBX_C = 0;
    localparam int CBX_Z = 1;
    localparam int CBX_N = 2;
    localparam int CBX_V = 3;
    localparam int CBX_S = 4;
    localparam int CBX_H = 5;
    localparam int CBX_T = 6;
    localparam int CBX_I = 7;
    // ==========================================================
    // Operation codes
    localparam logic [4:0] OP_BR_OVF_CLR  = 5'h00;
    localparam logic [4:0] OP_BR_IRQ_ON   = 5'h01;
    localparam logic [4:0] OP_BR_IRQ_OFF  = 5'h02;
    localparam logic [4:0] OP_IO_BIT_ONE  = 5'h03;
    localparam logic [4:0] OP_IO_BIT_ZERO = 5'h04;
    localparam logic [4:0] OP_SHL         = 5'h05;
    localparam logic [4:0] OP_SHR         = 5'h06;
    localparam logic [4:0] OP_ROL_C       = 5'h07;
    localparam logic [4:0] OP_ROR_C       = 5'h08;
    localparam logic [4:0] OP_ASHR        = 5'h09;
    localparam logic [4:0] OP_SWAP        = 5'h0a;
    localparam logic [4:0] OP_FLAG_SET    = 5'h0b;
    localparam logic [4:0] OP_FLAG_CLR    = 5'h0c;
    localparam logic [4:0] OP_BIT_TO_T    = 5'h0d;
    localparam logic [4:0] OP_T_TO_BIT    = 5'h0e;
    localparam logic [4:0] OP_COPY        = 5'h0f;
    localparam logic [4:0] OP_PAIR_COPY   = 5'h10;
    localparam logic [4:0] OP_LOAD_IMM    = 5'h11;
    localparam logic [4:0] OP_LD_X        = 5'h12;
    localparam logic [4:0] OP_LD_X_INC    = 5'h13;
    localparam logic [4:0] OP_LD_X_DEC    = 5'h14;
    localparam logic [4:0] OP_LD_Y        = 5'h15;
    localparam logic [4:0] OP_LD_Y_INC    = 5'h16;
    // ==========================================================
    // Pointer register numbers
    localparam logic [4:0] CBX_XL = 5'd26;
    localparam logic [4:0] CBX_XH = 5'd27;
    localparam logic [4:0] CBX_YL = 5'd28;
    localparam logic [4:0] CBX_YH = 5'd29;

    typedef struct packed {
        logic [5:0] unused;
        logic [7:0] k;
        logic [2:0] b;
        logic [4:0] rr;
        logic [4:0] rd;
        logic [4:0] op;
    } cbx_instr_s;

    typedef enum logic [1:0] {
        CBX_REG_CTRL,
        CBX_REG_GPR,
        CBX_REG_IO,
        CBX_REG_DMEM
    } cbx_region_e;

    typedef enum logic [1:0] {
        ST_IDLE,
        ST_RUN,
        ST_WAIT
    } cbx_state_e;
endpackage

// [cbx_core.sv]
// Chosen here: the placing of the registers and register access over APB.
`timescale 1ns/1ps
module cbx_core
    import cbx_pkg::*;
(
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [11:0] paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    output logic             busy
);
    // ==========================================================
    // Storage
    logic [7:0]  gpr_r  [CBX_GPR_N];
    logic [7:0]  io_r   [CBX_IO_N];
    logic [7:0]  dmem_r [CBX_DMEM_N];
    logic [7:0]  status_register_r;
    logic [15:0] pc_r;
    cbx_instr_s  ins_r;
    cbx_state_e  state_r;
    logic        taken_r;
    logic [1:0]  cyc_r;
    logic [31:0] prdata_r;
    logic        pready_r;
    logic        pslverr_r;
    function automatic cbx_region_e region(input logic [11:0] a);
        if (a[11:10] != 2'b00)
            return CBX_REG_DMEM;
        else if (a[9:8] == 2'b10)
            return CBX_REG_IO;
        else if (a[9:8] == 2'b01)
            return CBX_REG_GPR;
        else
            return CBX_REG_CTRL;
    endfunction
    // ==========================================================
    // APB decode
    wire         setup_w  = psel & ~penable;
    wire         wr_fire  = psel & penable & pwrite & pready_r;
    cbx_region_e reg_w;
    assign reg_w = region(paddr);
    wire [4:0]   gidx_w   = paddr[6:2];
    wire [7:0]   didx_w   = paddr[9:2];
    wire         ctl_ok   = (paddr[9:4] == 6'h00) && (paddr[1:0] == 2'b00);
    wire         hi_ok    = (paddr[7] == 1'b0) && (paddr[1:0] == 2'b00);
    wire         mapped_w = (reg_w == CBX_REG_CTRL) ? ctl_ok :
                            (reg_w == CBX_REG_DMEM) ? (paddr[1:0] == 2'b00)
                                                    : hi_ok;
    wire [31:0]  stat_w   = {26'h0, cyc_r, 2'b00, taken_r, busy};
    logic [31:0] ctl_rd_w;
    always_comb begin
        case (paddr[3:2])
            2'd0:    ctl_rd_w = ins_r;
            2'd1:    ctl_rd_w = stat_w;
            2'd2:    ctl_rd_w = {24'h0, status_register_r};
            default: ctl_rd_w = {16'h0, pc_r};
        endcase
    end
    wire [31:0]  rd_w     = ~mapped_w ? 32'h0 :
                            (reg_w == CBX_REG_CTRL) ? ctl_rd_w :
                            (reg_w == CBX_REG_GPR) ? {24'h0, gpr_r[gidx_w]} :
                            (reg_w == CBX_REG_IO) ? {24'h0, io_r[gidx_w]} :
                            {24'h0, dmem_r[didx_w]};
    // Writes are refused while an instruction runs so state stays coherent
    wire         sw_wr    = wr_fire & mapped_w & ~busy;
    wire         go_w     = sw_wr & (reg_w == CBX_REG_CTRL)
                            & (paddr[3:2] == 2'd0);

    // ==========================================================
    // Execution datapath
    wire [4:0]  op    = ins_r.op;
    wire [4:0]  rd    = ins_r.rd;
    wire [7:0]  a_w   = gpr_r[rd];
    wire [7:0]  b_w   = gpr_r[ins_r.rr];
    wire [15:0] x_w   = {gpr_r[CBX_XH], gpr_r[CBX_XL]};
    wire [15:0] y_w   = {gpr_r[CBX_YH], gpr_r[CBX_YL]};
    wire        run   = (state_r == ST_RUN);
    wire [15:0] pc1_w = pc_r + 16'h0001;
    wire [15:0] tgt_w = pc1_w + {{8{ins_r.k[7]}}, ins_r.k};
    logic [7:0]  res;
    logic        res_we;
    logic        shf;
    logic        c_new;
    logic [7:0]  status_register_nxt;
    logic        take;
    logic        two;
    logic [15:0] ptr_nxt;
    logic        x_we;
    logic        y_we;
    logic [7:0]  dadr;
    always_comb begin
        res = a_w;
        res_we = 1'b0;
        shf = 1'b0;
        c_new = status_register_r[CBX_C];
        status_register_nxt = status_register_r;
        take = 1'b0;
        two = 1'b0;
        ptr_nxt = x_w;
        x_we = 1'b0;
        y_we = 1'b0;
        dadr = x_w[7:0];
        case (op)
            OP_BR_OVF_CLR: take = ~status_register_r[CBX_V];
            OP_BR_IRQ_ON:  take = status_register_r[CBX_I];
            OP_BR_IRQ_OFF: take = ~status_register_r[CBX_I];
            OP_IO_BIT_ONE, OP_IO_BIT_ZERO: two = 1'b1;
            OP_SHL: begin
                res = {a_w[6:0], 1'b0};
                c_new = a_w[7];
                shf = 1'b1;
            end
            OP_SHR: begin
                res = {1'b0, a_w[7:1]};
                c_new = a_w[0];
                shf = 1'b1;
            end
            OP_ROL_C: begin
                res = {a_w[6:0], status_register_r[CBX_C]};
                c_new = a_w[7];
                shf = 1'b1;
            end
            OP_ROR_C: begin
                res = {status_register_r[CBX_C], a_w[7:1]};
                c_new = a_w[0];
                shf = 1'b1;
            end
            OP_ASHR: begin
                res = {a_w[7], a_w[7:1]};
                c_new = a_w[0];
                shf = 1'b1;
            end
            OP_SWAP: begin
                res = {a_w[3:0], a_w[7:4]};
                res_we = 1'b1;
            end
            // Fixed-flag opcodes are this pair with a constant index
            OP_FLAG_SET: status_register_nxt[ins_r.b] = 1'b1;
            OP_FLAG_CLR: status_register_nxt[ins_r.b] = 1'b0;
            OP_BIT_TO_T: status_register_nxt[CBX_T] = b_w[ins_r.b];
            OP_T_TO_BIT: begin
                res[ins_r.b] = status_register_r[CBX_T];
                res_we = 1'b1;
            end
            OP_COPY: begin
                res = b_w;
                res_we = 1'b1;
            end
            OP_LOAD_IMM: begin
                res = ins_r.k;
                res_we = 1'b1;
            end
            OP_LD_X, OP_LD_X_INC: begin
                res = dmem_r[x_w[7:0]];
                res_we = 1'b1;
                two = 1'b1;
                ptr_nxt = x_w + 16'h0001;
                x_we = (op == OP_LD_X_INC);
            end
            OP_LD_X_DEC: begin
                ptr_nxt = x_w - 16'h0001;
                dadr = ptr_nxt[7:0];
                res = dmem_r[dadr];
                res_we = 1'b1;
                two = 1'b1;
                x_we = 1'b1;
            end
            OP_LD_Y, OP_LD_Y_INC: begin
                res = dmem_r[y_w[7:0]];
                res_we = 1'b1;
                two = 1'b1;
                ptr_nxt = y_w + 16'h0001;
                y_we = (op == OP_LD_Y_INC);
            end
            default: ;
        endcase
        if (shf) begin
            res_we = 1'b1;
            status_register_nxt[CBX_C] = c_new;
            status_register_nxt[CBX_Z] = (res == 8'h00);
            status_register_nxt[CBX_N] = res[7];
            status_register_nxt[CBX_V] = res[7] ^ c_new;
        end
        if (take)
            two = 1'b1;
    end

    // ==========================================================
    // Sequencer: a two-cycle instruction holds in ST_WAIT one cycle
    cbx_state_e state_nxt;
    always_comb begin
        case (state_r)
            ST_IDLE: state_nxt = go_w ? ST_RUN : ST_IDLE;
            ST_RUN:  state_nxt = two ? ST_WAIT : ST_IDLE;
            ST_WAIT: state_nxt = ST_IDLE;
            default: state_nxt = ST_IDLE;
        endcase
    end
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_r   <= ST_IDLE;
            ins_r     <= '0;
            status_register_r    <= CBX_STATUS_REGISTER_RST;
            pc_r      <= CBX_PC_RST;
            taken_r   <= 1'b0;
            cyc_r     <= 2'd0;
            busy      <= 1'b0;
            prdata_r  <= 32'h0;
            pready_r  <= 1'b0;
            pslverr_r <= 1'b0;
        end else begin
            state_r   <= state_nxt;
            busy      <= (state_nxt != ST_IDLE);
            pready_r  <= setup_w;
            if (setup_w) begin
                prdata_r  <= rd_w;
                pslverr_r <= ~mapped_w;
            end
            if (go_w)
                ins_r <= cbx_instr_s'(pwdata);
            if (run) begin
                status_register_r  <= status_register_nxt;
                pc_r    <= take ? tgt_w : pc1_w;
                taken_r <= take;
                cyc_r   <= two ? 2'd2 : 2'd1;
            end else if (sw_wr && reg_w == CBX_REG_CTRL) begin
                if (paddr[3:2] == 2'd2)
                    status_register_r <= pwdata[7:0];
                if (paddr[3:2] == 2'd3)
                    pc_r <= pwdata[15:0];
            end
        end
    end

    // Arrays carry no reset; software loads them before use
    always_ff @(posedge pclk) begin
        if (run && res_we)
            gpr_r[rd] <= res;
        if (run && op == OP_PAIR_COPY) begin
            gpr_r[{rd[4:1], 1'b0}] <= gpr_r[{ins_r.rr[4:1], 1'b0}];
            gpr_r[{rd[4:1], 1'b1}] <= gpr_r[{ins_r.rr[4:1], 1'b1}];
        end
        // Pointer write follows the load, so it wins on overlap
        if (run && x_we)
            {gpr_r[CBX_XH], gpr_r[CBX_XL]} <= ptr_nxt;
        if (run && y_we)
            {gpr_r[CBX_YH], gpr_r[CBX_YL]} <= ptr_nxt;
        if (run && op == OP_IO_BIT_ONE)
            io_r[ins_r.rr][ins_r.b] <= 1'b1;
        if (run && op == OP_IO_BIT_ZERO)
            io_r[ins_r.rr][ins_r.b] <= 1'b0;
        if (sw_wr && reg_w == CBX_REG_GPR)
            gpr_r[gidx_w] <= pwdata[7:0];
        if (sw_wr && reg_w == CBX_REG_IO)
            io_r[gidx_w] <= pwdata[7:0];
        if (sw_wr && reg_w == CBX_REG_DMEM)
            dmem_r[didx_w] <= pwdata[7:0];
    end

    assign prdata  = prdata_r;
    assign pready  = pready_r;
    assign pslverr = pslverr_r;

    // ==========================================================
    // Assertions
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    AST_OVF_BRANCH: assert property (
        run && op == OP_BR_OVF_CLR && !status_register_r[CBX_V]
        |=> pc_r == $past(tgt_w) && state_r == ST_WAIT ##1 state_r == ST_IDLE)
        else $error("overflow-clear branch target or timing wrong");
    AST_IRQ_BRANCH: assert property (
        run && (op == OP_BR_IRQ_ON || op == OP_BR_IRQ_OFF)
        |=> status_register_r == $past(status_register_r)
            && taken_r == ($past(status_register_r[CBX_I]) == (op == OP_BR_IRQ_ON)))
        else $error("interrupt branch decision or flags wrong");
    AST_IO_SET: assert property (
        run && op == OP_IO_BIT_ONE
        |=> io_r[ins_r.rr][ins_r.b] && busy ##1 !busy)
        else $error("io bit force one wrong");
    AST_SHIFT_LEFT: assert property (
        run && op == OP_SHL
        |=> gpr_r[rd] == {$past(a_w[6:0]), 1'b0}
            && status_register_r[CBX_C] == $past(a_w[7]) && !busy)
        else $error("shift left result or carry wrong");
    AST_ROR: assert property (
        run && op == OP_ROR_C
        |=> gpr_r[rd][7] == $past(status_register_r[CBX_C])
            && status_register_r[CBX_C] == $past(a_w[0]))
        else $error("rotate right carry path wrong");
    AST_BIT_T: assert property (
        run && op == OP_BIT_TO_T
        |=> status_register_r[CBX_T] == $past(b_w[ins_r.b])
            && status_register_r[5:0] == $past(status_register_r[5:0]))
        else $error("bit to T copy wrong");
    AST_X_INC: assert property (
        run && op == OP_LD_X_INC && rd[4:1] != 4'd13
        |=> x_w == $past(x_w) + 16'h0001 ##1 !busy)
        else $error("post-increment of X wrong");
    AST_X_DEC: assert property (
        run && op == OP_LD_X_DEC && rd[4:1] != 4'd13
        |=> gpr_r[rd] == dmem_r[x_w[7:0]]
            && x_w == $past(x_w) - 16'h0001)
        else $error("pre-decrement load via X wrong");
    AST_COPY: assert property (
        run && op == OP_COPY
        |=> gpr_r[rd] == $past(b_w) && status_register_r == $past(status_register_r))
        else $error("register copy wrong");

    CV_BRANCH_TAKEN: cover property (run && take);
    CV_LOAD_Y_INC:   cover property (run && op == OP_LD_Y_INC);
    CV_FLAG_SET:     cover property (run && op == OP_FLAG_SET);
    CV_BUSY_WRITE:   cover property (wr_fire && busy);
endmodule

// [tb.sv]
`timescale 1ns/1ps
module tb
    import cbx_pkg::*;
;
    // ==========================================================
    // Clock, reset and bus signals
    logic        pclk    = 1'b0;
    logic        presetn = 1'b0;
    logic        psel    = 1'b0;
    logic        penable = 1'b0;
    logic        pwrite  = 1'b0;
    logic [11:0] paddr   = 12'h000;
    logic [31:0] pwdata  = 32'h0;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
    logic        busy;
    logic [31:0] seed    = 32'h27;
    logic [32:0] exp_q[$];
    logic [32:0] msk_q[$];
    int          bsy_q[$];
    int          bsy_n   = 0;
    int          bsy_e;
    int          fail_count  = 0;
    int          check_count = 0;

    always #10 pclk = ~pclk;

    cbx_core i_cbx_core (
        .pclk    (pclk),
        .presetn (presetn),
        .psel    (psel),
        .penable (penable),
        .pwrite  (pwrite),
        .paddr   (paddr),
        .pwdata  (pwdata),
        .prdata  (prdata),
        .pready  (pready),
        .pslverr (pslverr),
        .busy    (busy)
    );

    // ==========================================================
    // Helpers
    function automatic logic [31:0] rnd();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction

    function automatic logic [11:0] ga(input logic [4:0] i);
        return CBX_GPR_BASE + {5'h0, i, 2'b0};
    endfunction

    task automatic results();
        $display("checks %0d mismatches %0d", check_count, fail_count);
        if (fail_count == 0 && check_count > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask

    task automatic chk(input logic [32:0] g, input logic [32:0] e,
                       input logic [32:0] m);
        check_count++;
        if ((g & m) !== (e & m)) begin
            fail_count++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, g & m, e & m);
        end
    endtask

    // On writes the mask keeps read data out of the compare; only the error flag counts
    task automatic apb(input logic w, input logic [11:0] a,
                       input logic [31:0] d, input logic [32:0] e,
                       input logic [32:0] m);
        exp_q.push_back(e);
        msk_q.push_back(m);
        @(posedge pclk);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= w;
        paddr   <= a;
        pwdata  <= d;
        @(posedge pclk);
        penable <= 1'b1;
        // Only the watchdog ends a wait for the slave
        do begin
            @(posedge pclk);
        end while (pready !== 1'b1);
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        apb(1'b1, a, d, 33'h0, 33'h1_0000_0000);
    endtask

    task automatic rdc(input logic [11:0] a, input logic [31:0] e);
        apb(1'b0, a, 32'h0, {1'b0, e}, '1);
    endtask

    // Expected busy length is noted first; a hang falls to the watchdog
    task automatic exec(input logic [31:0] w, input int c);
        bsy_q.push_back(c);
        wr(CBX_INSTR_OFS, w);
        while (busy !== 1'b1) begin
            @(posedge pclk);
        end
        while (busy !== 1'b0) begin
            @(posedge pclk);
        end
    endtask

    // ==========================================================
    // Result monitor
    always @(posedge pclk) begin
        if (psel && penable && pready === 1'b1 && exp_q.size() > 0) begin
            chk({pslverr, prdata}, exp_q.pop_front(), msk_q.pop_front());
        end
    end

    // Busy length in cycles; a rise with no note counts as a mismatch
    always @(posedge pclk) begin
        if (busy === 1'b1) begin
            bsy_n <= bsy_n + 1;
        end else if (bsy_n != 0) begin
            bsy_e = (bsy_q.size() > 0) ? bsy_q.pop_front() : 0;
            chk(33'(bsy_n), 33'(bsy_e), '1);
            bsy_n <= 0;
        end
    end

    // ==========================================================
    // One instruction with random operands and a reference result
    task automatic run_op(input logic [4:0] op, input logic [2:0] b);
        logic [31:0] x;
        logic [7:0]  a, a2, bv, b2, m, s, r, r2, es, k, io;
        logic [4:0]  di, si, pl;
        logic [15:0] pc, p, ea, np, epc;
        logic        c, tk, cy2;
        x = rnd();
        a = x[7:0];
        a2 = x[15:8];
        bv = x[23:16];
        b2 = x[31:24];
        x = rnd();
        m = x[7:0];
        k = x[15:8];
        s = x[23:16];
        di = {1'b0, x[29:27], 1'b0};
        si = {2'b10, x[31:30], 1'b0};
        x = rnd();
        pc = x[15:0];
        p = x[31:16];
        s[CBX_V] = b[0];
        s[CBX_I] = b[1];
        if (op == OP_BIT_TO_T) bv = a;
        pl = (op >= OP_LD_Y) ? CBX_YL : CBX_XL;
        ea = (op == OP_LD_X_DEC) ? p - 16'h1 : p;
        np = (op == OP_LD_X_INC || op == OP_LD_Y_INC) ? p + 16'h1 : ea;
        wr(ga(di), {24'h0, a});
        wr(ga(di + 5'd1), {24'h0, a2});
        wr(ga(si), {24'h0, bv});
        wr(ga(si + 5'd1), {24'h0, b2});
        wr(ga(pl), {24'h0, p[7:0]});
        wr(ga(pl + 5'd1), {24'h0, p[15:8]});
        wr(CBX_DMEM_BASE + {2'b0, ea[7:0], 2'b0}, {24'h0, m});
        wr(CBX_IO_BASE + {5'h0, si, 2'b0}, {24'h0, bv});
        wr(CBX_STATUS_REGISTER_OFS, {24'h0, s});
        wr(CBX_PC_OFS, {16'h0, pc});
        r = a;
        r2 = a2;
        es = s;
        io = bv;
        c = s[CBX_C];
        tk = 1'b0;
        cy2 = (op == OP_IO_BIT_ONE || op == OP_IO_BIT_ZERO || op >= OP_LD_X);
        case (op)
            OP_BR_OVF_CLR:  tk = ~s[CBX_V];
            OP_BR_IRQ_ON:   tk = s[CBX_I];
            OP_BR_IRQ_OFF:  tk = ~s[CBX_I];
            OP_IO_BIT_ONE:  io[b] = 1'b1;
            OP_IO_BIT_ZERO: io[b] = 1'b0;
            OP_SHL:         {c, r} = {a, 1'b0};
            OP_SHR:         {r, c} = {1'b0, a};
            OP_ROL_C:       {c, r} = {a, s[CBX_C]};
            OP_ROR_C:       {r, c} = {s[CBX_C], a};
            OP_ASHR:        {r, c} = {a[7], a};
            OP_SWAP:        r = {a[3:0], a[7:4]};
            OP_FLAG_SET:    es[b] = 1'b1;
            OP_FLAG_CLR:    es[b] = 1'b0;
            OP_BIT_TO_T:    es[CBX_T] = bv[b];
            OP_T_TO_BIT:    r[b] = s[CBX_T];
            OP_COPY:        r = bv;
            OP_PAIR_COPY:   {r2, r} = {b2, bv};
            OP_LOAD_IMM:    r = k;
            default:        r = m;
        endcase
        if (op >= OP_SHL && op <= OP_ASHR) begin
            es[3:0] = {r[7] ^ c, r[7], r == 8'h0, c};
        end
        epc = pc + 16'h1 + (tk ? {{8{k[7]}}, k} : 16'h0);
        exec({6'h0, k, b, si, di, op}, (tk | cy2) ? 2 : 1);
        rdc(ga(di), {24'h0, r});
        rdc(ga(di + 5'd1), {24'h0, r2});
        rdc(ga(pl), {24'h0, np[7:0]});
        rdc(ga(pl + 5'd1), {24'h0, np[15:8]});
        rdc(CBX_IO_BASE + {5'h0, si, 2'b0}, {24'h0, io});
        rdc(CBX_STATUS_REGISTER_OFS, {24'h0, es});
        rdc(CBX_PC_OFS, {16'h0, epc});
        rdc(CBX_STATUS_OFS,
            {26'h0, tk | cy2, ~(tk | cy2), 2'b0, tk, 1'b0});
        $display("op %h bit %h done", op, b);
    endtask

    // ==========================================================
    // Main sequence
    initial begin
        repeat (4) @(posedge pclk);
        presetn <= 1'b1;
        rdc(CBX_STATUS_REGISTER_OFS, {24'h0, CBX_STATUS_REGISTER_RST});
        rdc(CBX_PC_OFS, {16'h0, CBX_PC_RST});
        rdc(CBX_STATUS_OFS, 32'h0);
        $display("reset test done");
        apb(1'b0, 12'h010, 32'h0, {1'b1, 32'h0}, '1);
        apb(1'b0, 12'h102, 32'h0, {1'b1, 32'h0}, '1);
        apb(1'b1, 12'h300, 32'h5a, {1'b1, 32'h0}, 33'h1_0000_0000);
        $display("unmapped test done");
        // Bit index sweeps every flag and bit position across passes
        for (int it = 0; it < 8; it++) begin
            for (int op = 0; op <= 22; op++) begin
                run_op(5'(op), 3'(it));
            end
        end
        results();
    end

    // Whole run needs roughly 11000 cycles; allow well beyond that
    initial begin
        #(60000 * 20);
        fail_count++;
        $display("[ERR] t=%0t timeout", $time);
        results();
    end
endmodule
